// File: rtl/cfg_loader_consts.svh
// Constants for the startup configuration loader
`ifndef CFG_LOADER_CONSTS_SVH
`define CFG_LOADER_CONSTS_SVH
`define NV_ADDR_W 13
`define REG_ADDR_W 7
`define NV_IMAGE_BASE 13'h0040
`define NV_TRIM_ADDR 13'h0010
`define NV_PROT_BASE 13'h1C00
`define NV_PROT_STRIDE 13'h0018
`define REG_COUNT 8'h50
`define PROT_COUNT 8'h18
`define PROT_REG_BASE 7'h28
`define RST_COMMAND 8'h40
`define RST_QUEUE_CONTROL 8'h80
`define RST_FIFO_THRESHOLD 8'h05
`endif

// File: rtl/cfg_loader_pkg.sv
// Types for the startup configuration loader
package cfg_loader_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BOOT_RD = 3'b001,
        ST_BOOT_WR = 3'b010,
        ST_PROT_RD = 3'b011,
        ST_PROT_WR = 3'b100
    } load_state_t;
endpackage : cfg_loader_pkg

// File: rtl/eeprom_register_default_loader.sv
// Copies stored register defaults from nonvolatile array into register file
`include "cfg_loader_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module eeprom_register_default_loader #(
    parameter int NV_READ_LATENCY = 1
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [12:0] image_base_in,
    input wire logic protocol_settings_load_in,
    input wire logic [7:0] protocol_sel_in,
    output logic [12:0] nv_addr_out,
    output logic nv_rd_out,
    input wire logic [7:0] nv_data_in,
    output logic [6:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic [7:0] reg_wmask_out,
    output logic reg_we_out,
    input wire logic [7:0] reg_rw_mask_in,
    output logic [7:0] slow_oscillator_trim_out,
    output logic host_ready_out,
    output logic busy_out
);
    import cfg_loader_pkg::*;

    load_state_t state_reg, state_next;
    logic [7:0] idx_reg, idx_next;
    logic [12:0] src_reg, src_next;
    logic [7:0] wait_reg, wait_next;
    logic trim_pending_reg, trim_pending_next;
    logic [7:0] trim_reg, trim_next;
    logic ready_reg, ready_next;
    logic [12:0] nv_addr_reg, nv_addr_next;
    logic nv_rd_reg, nv_rd_next;
    logic [6:0] waddr_reg, waddr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [7:0] wmask_reg, wmask_next;
    logic we_reg, we_next;
    logic [6:0] dst_base_reg, dst_base_next;
    logic busy_reg, busy_next;

    // Protocol area address: base plus selection times stride
    function automatic logic [12:0] prot_addr(input logic [7:0] sel);
        logic [20:0] prod;
        prod = 21'(sel) * 21'(`NV_PROT_STRIDE);
        return 13'(`NV_PROT_BASE + prod[12:0]);
    endfunction : prot_addr

    // Sequencer next state; reads wait a fixed latency before writing
    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        src_next = src_reg;
        wait_next = wait_reg;
        trim_pending_next = trim_pending_reg;
        trim_next = trim_reg;
        ready_next = ready_reg;
        nv_addr_next = nv_addr_reg;
        nv_rd_next = 1'b0;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wmask_next = wmask_reg;
        we_next = 1'b0;
        dst_base_next = dst_base_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (protocol_settings_load_in && ready_reg) begin
                    src_next = prot_addr(protocol_sel_in);
                    dst_base_next = `PROT_REG_BASE;
                    idx_next = 8'h00;
                    nv_addr_next = prot_addr(protocol_sel_in);
                    nv_rd_next = 1'b1;
                    wait_next = 8'(NV_READ_LATENCY);
                    state_next = ST_PROT_RD;
                end
            end
            ST_BOOT_RD, ST_PROT_RD: begin
                // Count down the full latency so data is taken once it stands
                if (wait_reg > 8'h00) begin
                    wait_next = wait_reg - 8'h01;
                end else begin
                    if (trim_pending_reg) begin
                        // Trim byte read first, then the image walk
                        trim_next = nv_data_in;
                        trim_pending_next = 1'b0;
                        // Image base is user changeable, taken at boot
                        src_next = image_base_in;
                        nv_addr_next = image_base_in;
                        nv_rd_next = 1'b1;
                        wait_next = 8'(NV_READ_LATENCY);
                    end else begin
                        waddr_next = 7'(dst_base_reg + 7'(idx_reg));
                        wdata_next = nv_data_in;
                        wmask_next = reg_rw_mask_in;
                        we_next = 1'b1;
                        state_next = (state_reg == ST_BOOT_RD) ?
                            ST_BOOT_WR : ST_PROT_WR;
                    end
                end
            end
            ST_BOOT_WR, ST_PROT_WR: begin
                if (idx_reg + 8'h01 >= ((state_reg == ST_BOOT_WR) ?
                        `REG_COUNT : `PROT_COUNT)) begin
                    ready_next = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    idx_next = idx_reg + 8'h01;
                    nv_addr_next = 13'(src_reg + 13'(idx_reg) + 13'h0001);
                    nv_rd_next = 1'b1;
                    wait_next = 8'(NV_READ_LATENCY);
                    state_next = (state_reg == ST_BOOT_WR) ?
                        ST_BOOT_RD : ST_PROT_RD;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Busy registered from the next state so the pin is a flop
        busy_next = (state_next != ST_IDLE);
    end

    // State registers; boot copy begins right after reset
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= ST_BOOT_RD;
            idx_reg <= 8'h00;
            src_reg <= `NV_IMAGE_BASE;
            wait_reg <= 8'h00;
            trim_pending_reg <= 1'b1;
            trim_reg <= 8'h00;
            ready_reg <= 1'b0;
            nv_addr_reg <= `NV_TRIM_ADDR;
            nv_rd_reg <= 1'b0;
            waddr_reg <= 7'h00;
            wdata_reg <= 8'h00;
            wmask_reg <= 8'h00;
            we_reg <= 1'b0;
            dst_base_reg <= 7'h00;
            busy_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            src_reg <= src_next;
            wait_reg <= wait_next;
            trim_pending_reg <= trim_pending_next;
            trim_reg <= trim_next;
            ready_reg <= ready_next;
            nv_addr_reg <= nv_addr_next;
            nv_rd_reg <= nv_rd_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wmask_reg <= wmask_next;
            we_reg <= we_next;
            dst_base_reg <= dst_base_next;
            busy_reg <= busy_next;
        end
    end

    // Outputs straight from flip-flops
    assign nv_addr_out = nv_addr_reg;
    assign nv_rd_out = nv_rd_reg;
    assign reg_addr_out = waddr_reg;
    assign reg_wdata_out = wdata_reg;
    assign reg_wmask_out = wmask_reg;
    assign reg_we_out = we_reg;
    assign slow_oscillator_trim_out = trim_reg;
    assign host_ready_out = ready_reg;
    assign busy_out = busy_reg;

    // Sampling clock and reset shared by every check below
    default clocking cb_main @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    // Strobe to write distance: array latency plus the take cycle
    localparam int RD_TO_WR = NV_READ_LATENCY + 1;

    // Steps of one copied byte
    sequence s_nv_read;
        nv_rd_out;
    endsequence
    sequence s_reg_write;
        reg_we_out;
    endsequence

    // Writes never touch bits outside the writable mask
    a_write_masked: assert property (
        reg_we_out |-> reg_wmask_out == $past(reg_rw_mask_in))
        else $error("write mask not taken from access mask");

    // Host held off while boot copy runs
    a_hold_host: assert property (
        (state_reg == ST_BOOT_RD || state_reg == ST_BOOT_WR)
        |-> !host_ready_out)
        else $error("host released during boot copy");

    // Protocol load starts from the selected area
    a_prot_src: assert property (
        (state_reg == ST_IDLE && protocol_settings_load_in && host_ready_out)
        |=> nv_rd_out && nv_addr_out == prot_addr($past(protocol_sel_in)))
        else $error("protocol load source wrong");

    // Each write is followed by the next read or idle
    a_walk_step: assert property (
        reg_we_out |=> (nv_rd_out || state_reg == ST_IDLE))
        else $error("copy walk stalled");

    // Every strobed array read lands as one register write RD_TO_WR cycles later
    a_read_write: assert property (
        s_nv_read |-> ##RD_TO_WR s_reg_write)
        else $error("read not followed by register write");

    // Protocol writes never land below the protocol register window
    a_prot_dest: assert property (
        (reg_we_out && state_reg == ST_PROT_WR)
        |-> reg_addr_out >= `PROT_REG_BASE)
        else $error("protocol write below its window");

    // Once released, host access stays open until the next reset
    a_ready_sticky: assert property (
        host_ready_out |=> host_ready_out)
        else $error("host access withdrawn");

    // Busy shown for the whole protocol load
    a_busy_load: assert property (
        (state_reg == ST_PROT_RD || state_reg == ST_PROT_WR) |-> busy_out)
        else $error("busy low during protocol load");

    // A protocol load never disturbs the oscillator trim
    a_trim_frozen: assert property (
        state_reg == ST_PROT_RD |-> $stable(slow_oscillator_trim_out))
        else $error("trim changed by protocol load");
endmodule : eeprom_register_default_loader
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the startup configuration loader
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] MASK = 8'hFE;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic load = 1'b0;
    logic [7:0] sel = 8'h00;
    logic [7:0] nv_data = 8'h00;
    logic [12:0] nv_addr;
    logic [6:0] reg_addr;
    logic [7:0] wdata, wmask, trim;
    logic we, rd, ready, busy;
    logic [7:0] mem [0:8191];
    logic [7:0] regs [0:127];
    int fail_count = 0;
    int n_compared = 0;
    int n_wr = 0;
    int cyc = 0;

    eeprom_register_default_loader i_dut (.clk_in(clk_in),
        .reset_in(reset_in), .image_base_in(13'h0040),
        .protocol_settings_load_in(load), .protocol_sel_in(sel),
        .nv_addr_out(nv_addr), .nv_rd_out(rd), .nv_data_in(nv_data),
        .reg_addr_out(reg_addr), .reg_wdata_out(wdata),
        .reg_wmask_out(wmask), .reg_we_out(we), .reg_rw_mask_in(MASK),
        .slow_oscillator_trim_out(trim), .host_ready_out(ready),
        .busy_out(busy));

    always #10 clk_in = ~clk_in;

    task automatic test_done;
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Array answers one cycle late; register file keeps only masked bits
    always @(posedge clk_in) begin
        nv_data <= mem[nv_addr];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
        if (we) begin
            regs[reg_addr] <= (regs[reg_addr] & ~wmask) | (wdata & wmask);
            n_wr <= n_wr + 1;
            chk("wmask", MASK, wmask);
        end
    end

    // Bounded wait until the loader is ready and idle
    task automatic wait_idle;
        for (int k = 0; k < 2000 && (busy !== 1'b0 || ready !== 1'b1); k++)
            @(posedge clk_in);
    endtask : wait_idle

    // Reset, poke a load mid-boot, then check the whole default image
    task automatic boot_check;
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        for (int i = 0; i < 128; i++) regs[i] = 8'h00;
        n_wr = 0;
        reset_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        load <= 1'b1;
        @(posedge clk_in);
        load <= 1'b0;
        wait_idle();
        chk("trim", mem[16], trim);
        chk("boot_writes", 8'h50, n_wr[7:0]);
        chk("cmd", 8'h40 & MASK, regs[0]);
        for (int i = 0; i < 8'h50; i++)
            chk("boot_reg", mem[13'h40 + i] & MASK, regs[i]);
    endtask : boot_check

    // Protocol load: window of registers replaced, neighbours kept
    task automatic prot_check(input logic [7:0] s);
        n_wr = 0;
        sel <= s;
        load <= 1'b1;
        @(posedge clk_in);
        load <= 1'b0;
        #1 chk("rd", 8'h01, {7'h00, rd});
        chk("ready", 8'h01, {7'h00, ready});
        @(posedge clk_in);
        #1 chk("busy", 8'h01, {7'h00, busy});
        wait_idle();
        chk("prot_writes", 8'h18, n_wr[7:0]);
        chk("below", mem[13'h67] & MASK, regs[8'h27]);
        chk("above", mem[13'h80] & MASK, regs[8'h40]);
        for (int i = 0; i < 8'h18; i++)
            chk("prot_reg", mem[13'h1C00 + s * 8'h18 + i] & MASK,
                regs[8'h28 + i]);
    endtask : prot_check

    // Main sequence
    initial begin
        for (int a = 0; a < 8192; a++) mem[a] = 8'(a * 7 + 3);
        mem[13'h40] = 8'h40;
        mem[13'h42] = 8'h80;
        mem[13'h43] = 8'h05;
        boot_check();
        prot_check(8'h00);
        prot_check(8'h02);
        // Host rewrites stored defaults; next startup must use them
        mem[13'h41] = 8'h5A;
        mem[13'h8F] = 8'hC3;
        mem[16] = 8'h77;
        boot_check();
        test_done();
    end
endmodule : testbench
`default_nettype wire
